// ==== hbridge_spi_host.sv ====
// Host end: command FIFO, serial master and pin drive for the bridge.
// Assumes the device answers on the shared link; user logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wrPtr;
	logic [PW:0]      rdPtr;

	assign outValid = (wrPtr != rdPtr);
	assign inReady  = (wrPtr[PW-1:0] != rdPtr[PW-1:0]) ||
		(wrPtr[PW] == rdPtr[PW]);
	assign outData  = mem[rdPtr[PW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (inValid && inReady) begin
			mem[wrPtr[PW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr <= wrPtr + (PW+1)'(1);
			end
			if (outValid && outReady) begin
				rdPtr <= rdPtr + (PW+1)'(1);
			end
		end
	end
endmodule

module hbridge_spi_host
	import hbridge_pkg::*;
#(
	parameter int FRAME_BITS = WORD_W,
	parameter int HALF       = SCLK_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// Link to the device
	hbridge_link_if.host               link,
	// Command stream
	input  wire logic                  cmdValid,
	output logic                       cmdReady,
	input  wire logic [FRAME_BITS-1:0] cmdData,
	// Answers
	output logic                       rspValid,
	output logic      [FRAME_BITS-1:0] rspData,
	// Pin requests
	input  wire logic                  sleepEnable,
	input  wire logic                  outputDisable,
	input  wire logic                  dirA,
	input  wire logic                  dirB,
	output logic                       faultSeen
);
	localparam int HW = $clog2(HALF + 1);
	localparam int BW = $clog2(FRAME_BITS + 1);

	// ==========================================================
	// Input synchronisers
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] clean;
	logic [1:0] pinRaw;

	assign pinRaw = {link.faultFlagN, link.miso};

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					sync1[p] <= 1'b1;
					sync2[p] <= 1'b1;
					sync3[p] <= 1'b1;
					clean[p] <= 1'b1;
				end else begin
					sync1[p] <= pinRaw[p];
					sync2[p] <= sync1[p];
					sync3[p] <= sync2[p];
					if (sync2[p] == sync3[p]) begin
						clean[p] <= sync3[p];
					end
				end
			end
		end
	endgenerate

	assign faultSeen = ~clean[1];

	// ==========================================================
	// Command FIFO
	logic                  qValid;
	logic                  qReady;
	logic [FRAME_BITS-1:0] qData;
	host_state_t           state;

	stream_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.inValid  (cmdValid),
		.inReady  (cmdReady),
		.inData   (cmdData),
		.outValid (qValid),
		.outReady (qReady),
		.outData  (qData)
	);

	assign qReady = (state == HOST_IDLE);

	// ==========================================================
	// Serial clock divider
	logic [HW-1:0] halfCnt;
	logic          tick;

	assign tick = (halfCnt == HW'(HALF - 1));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			halfCnt <= '0;
		end else if (state == HOST_IDLE || tick) begin
			halfCnt <= '0;
		end else begin
			halfCnt <= halfCnt + HW'(1);
		end
	end

	// ==========================================================
	// Frame sequencer
	// MOSI moves on the rising edge, half a period clear of the
	// falling edge at which the device samples it.
	// MISO is taken at the end of the low phase. The device answers a
	// rising edge only after both synchronisers, too late for the fall.
	logic [FRAME_BITS-1:0] txShift;
	logic [FRAME_BITS-1:0] rxShift;
	logic [BW-1:0]         bitCnt;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state     <= HOST_IDLE;
			link.csN  <= 1'b1;
			link.sclk <= 1'b0;
			link.mosi <= 1'b0;
			txShift   <= '0;
			rxShift   <= '0;
			bitCnt    <= '0;
			rspValid  <= 1'b0;
			rspData   <= '0;
		end else begin
			rspValid <= 1'b0;
			unique case (state)
				HOST_IDLE: begin
					if (qValid) begin
						link.csN  <= 1'b0;
						link.mosi <= qData[FRAME_BITS-1];
						txShift   <= qData;
						bitCnt    <= '0;
						state     <= HOST_LEAD;
					end
				end
				HOST_LEAD: begin
					if (tick) begin
						link.sclk <= 1'b1;
						state     <= HOST_HIGH;
					end
				end
				HOST_HIGH: begin
					if (tick) begin
						link.sclk <= 1'b0;
						bitCnt    <= bitCnt + BW'(1);
						state     <= HOST_LOW;
					end
				end
				HOST_LOW: begin
					if (tick) begin
						rxShift <= {rxShift[FRAME_BITS-2:0], clean[0]};
						if (bitCnt == BW'(FRAME_BITS)) begin
							link.csN <= 1'b1;
							state    <= HOST_TRAIL;
						end else begin
							link.sclk <= 1'b1;
							link.mosi <= txShift[FRAME_BITS-2];
							txShift   <= txShift << 1;
							state     <= HOST_HIGH;
						end
					end
				end
				HOST_TRAIL: begin
					if (tick) begin
						rspValid <= 1'b1;
						rspData  <= rxShift;
						state    <= HOST_IDLE;
					end
				end
				default: state <= HOST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Mode and direction pins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			link.sleepEnableInput   <= 1'b0;
			link.outputDisableInput <= 1'b1;
			link.directionInputA    <= 1'b0;
			link.directionInputB    <= 1'b0;
		end else begin
			link.sleepEnableInput   <= sleepEnable;
			link.outputDisableInput <= outputDisable;
			link.directionInputA    <= dirA;
			link.directionInputB    <= dirB;
		end
	end
endmodule

`default_nettype wire

// ==== hbridge_pkg.sv ====
// Shared constants for the H-bridge serial control link and its two ends.
// Assumes a single 100 MHz system clock at both ends.
package hbridge_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS    = 10;
	localparam int SCLK_PERIOD_NS   = 160;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int DEAD_BASE_NS     = 200;
	localparam int DEAD_BASE_CYCLES =
		(DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_W           = 8;

	// ==========================================================
	// Serial word layout
	localparam int WORD_W  = 16;
	localparam int CNT_W   = 5;
	localparam int WR_BIT  = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 13;
	localparam int ADDR_W  = 2;
	localparam int DATA_W  = 13;

	// ==========================================================
	// Internal registers
	localparam logic [ADDR_W-1:0] ADDR_FAULT = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_MASK  = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_SLEW  = 2'h2;
	localparam int FAULT_W = 8;
	localparam int SLEW_W  = 3;
	localparam logic [FAULT_W-1:0] MASK_RESET = 8'hFF;
	localparam logic [SLEW_W-1:0]  SLEW_RESET = 3'h3;

	// ==========================================================
	// Device pin synchroniser lanes
	localparam int PIN_CS    = 0;
	localparam int PIN_SCLK  = 1;
	localparam int PIN_MOSI  = 2;
	localparam int PIN_SLEEP = 3;
	localparam int PIN_DIS   = 4;
	localparam int PIN_DIRA  = 5;
	localparam int PIN_DIRB  = 6;
	localparam int PIN_COUNT = 7;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 7'h01;

	// ==========================================================
	// Host side
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		HOST_IDLE  = 3'h0,
		HOST_LEAD  = 3'h1,
		HOST_HIGH  = 3'h3,
		HOST_LOW   = 3'h2,
		HOST_TRAIL = 3'h6
	} host_state_t;

endpackage

// ==== hbridge_link_if.sv ====
// Pin-level link between the host controller and the bridge device.
// Assumes both ends run from the same system clock and reset.
`timescale 1ns/1ps
`default_nettype none

interface hbridge_link_if;
	logic csN;
	logic sclk;
	logic mosi;
	logic misoOut;
	logic misoOe;
	logic miso;
	logic sleepEnableInput;
	logic outputDisableInput;
	logic directionInputA;
	logic directionInputB;
	logic faultFlagNOut;
	logic faultFlagNOe;
	logic faultFlagN;

	// ==========================================================
	// Wire resolution: pull-ups on idle lines
	assign miso       = misoOe ? misoOut : 1'b1;
	assign faultFlagN = faultFlagNOe ? faultFlagNOut : 1'b1;

	modport device (
		input  csN, sclk, mosi, sleepEnableInput, outputDisableInput,
		input  directionInputA, directionInputB,
		output misoOut, misoOe, faultFlagNOut, faultFlagNOe
	);

	modport host (
		output csN, sclk, mosi, sleepEnableInput, outputDisableInput,
		output directionInputA, directionInputB,
		input  miso, faultFlagN
	);
endinterface

`default_nettype wire

// ==== hbridge_spi_device.sv ====
// Bridge device end: serial slave, pin modes, gate drive, fault flag.
// Assumes the link carries host pins; fault conditions come from logic
// on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Sample MOSI on SCLK fall, change MISO on rise
// - Outgoing word leaves MSB first
// - Incoming word arrives MSB first
// - After 16 bits MISO echoes MOSI
// - Echo lasts until chip select rises
// - MISO driven only while chip select low
// - Select fall loads previously addressed register
// - Select rise commits word to addressed register
// - Daisy-chain slave through MOSI-to-MISO echo
// - Host drives MOSI only while selected; host here drives it always, holding its last level
// - Sleep enable low: drivers off, sleep
// - Sleep enable high: normal operation
// - Disable high: drivers off, standby only
// - Disable low does not inhibit outputs
// - Never both transistors of one leg
// - Direction inputs steer the drive
// - Direction change passes through dead time
// - Slew register sets switching timing
// - Masked active fault pulls flag low
// - Fault flag only pulls low
module hbridge_spi_device
	import hbridge_pkg::*;
#(
	parameter int DEAD_BASE = DEAD_BASE_CYCLES
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	// Link to the host
	hbridge_link_if.device          link,
	// Fault sources
	input  wire logic [FAULT_W-1:0] faultCond,
	// Bridge drive
	output logic      [1:0]         highSideOn,
	output logic      [1:0]         lowSideOn,
	output logic      [SLEW_W-1:0]  slewSetting,
	// Mode
	output logic                    sleepMode,
	output logic                    standbyMode
);

	// ==========================================================
	// Pin synchronisers
	logic [PIN_COUNT-1:0] sync1;
	logic [PIN_COUNT-1:0] sync2;
	logic [PIN_COUNT-1:0] sync3;
	logic [PIN_COUNT-1:0] clean;
	logic [PIN_COUNT-1:0] cleanPrev;
	logic [PIN_COUNT-1:0] pinRaw;

	assign pinRaw = {link.directionInputB, link.directionInputA,
		link.outputDisableInput, link.sleepEnableInput,
		link.mosi, link.sclk, link.csN};

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					sync1[p] <= PIN_RESET[p];
					sync2[p] <= PIN_RESET[p];
					sync3[p] <= PIN_RESET[p];
					clean[p] <= PIN_RESET[p];
					cleanPrev[p] <= PIN_RESET[p];
				end else begin
					sync1[p] <= pinRaw[p];
					sync2[p] <= sync1[p];
					sync3[p] <= sync2[p];
					// A level counts once two stages agree
					if (sync2[p] == sync3[p]) begin
						clean[p] <= sync3[p];
					end
					cleanPrev[p] <= clean[p];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Frame and clock edges
	logic selected;
	logic csFall;
	logic csRise;
	logic sclkRise;
	logic sclkFall;

	// Clock edges outside a frame are ignored
	assign selected = ~clean[PIN_CS];
	assign csFall   = cleanPrev[PIN_CS] & ~clean[PIN_CS];
	assign csRise   = ~cleanPrev[PIN_CS] & clean[PIN_CS];
	assign sclkRise = selected & ~cleanPrev[PIN_SCLK] & clean[PIN_SCLK];
	assign sclkFall = selected & cleanPrev[PIN_SCLK] & ~clean[PIN_SCLK];

	// ==========================================================
	// Internal registers
	logic [FAULT_W-1:0] faultMask;
	logic [SLEW_W-1:0]  slewReg;
	logic [ADDR_W-1:0]  prevAddr;
	logic [WORD_W-1:0]  shiftReg;
	logic [CNT_W-1:0]   bitCnt;
	logic               misoBit;
	logic [WORD_W-1:0]  readback;
	logic               fullWord;

	assign fullWord = (bitCnt == CNT_W'(WORD_W));

	always_comb begin
		readback = '0;
		readback[ADDR_HI:ADDR_LO] = prevAddr;
		unique case (prevAddr)
			ADDR_FAULT: readback[FAULT_W-1:0] = faultCond;
			ADDR_MASK:  readback[FAULT_W-1:0] = faultMask;
			ADDR_SLEW:  readback[SLEW_W-1:0]  = slewReg;
			default:    readback[FAULT_W-1:0] = '0;
		endcase
	end

	// Bit counter saturates: with a daisy chain the last 16 bits win
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bitCnt <= '0;
		end else if (csFall) begin
			bitCnt <= '0;
		end else if (sclkFall && !fullWord) begin
			bitCnt <= bitCnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			shiftReg <= '0;
		end else if (csFall) begin
			shiftReg <= readback;
		end else if (sclkFall) begin
			shiftReg <= {shiftReg[WORD_W-2:0], clean[PIN_MOSI]};
		end
	end

	// Once the status bits are gone the shifter holds received bits,
	// so the same path yields the echo and passes data down a chain
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			misoBit <= 1'b0;
		end else if (csFall) begin
			misoBit <= readback[WORD_W-1];
		end else if (sclkRise) begin
			misoBit <= shiftReg[WORD_W-1];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			faultMask <= MASK_RESET;
			slewReg   <= SLEW_RESET;
			prevAddr  <= ADDR_FAULT;
		end else if (csRise && fullWord) begin
			prevAddr <= shiftReg[ADDR_HI:ADDR_LO];
			if (shiftReg[WR_BIT]) begin
				unique case (shiftReg[ADDR_HI:ADDR_LO])
					ADDR_MASK: faultMask <= shiftReg[FAULT_W-1:0];
					ADDR_SLEW: slewReg <= shiftReg[SLEW_W-1:0];
					default: ;
				endcase
			end
		end
	end

	assign link.misoOut = misoBit;
	assign link.misoOe  = selected;

	// ==========================================================
	// Modes
	logic bridgeActive;

	assign bridgeActive = clean[PIN_SLEEP] & ~clean[PIN_DIS];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sleepMode   <= 1'b1;
			standbyMode <= 1'b0;
		end else begin
			sleepMode   <= ~clean[PIN_SLEEP];
			standbyMode <= clean[PIN_SLEEP] & clean[PIN_DIS];
		end
	end

	// ==========================================================
	// Gate drive with dead time per leg
	logic [DEAD_W-1:0] deadCycles;

	// Slower slew codes stretch the blanking between the two switches
	assign deadCycles = DEAD_W'(DEAD_BASE * (int'(slewReg) + 1));
	assign slewSetting = slewReg;

	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : g_leg
			localparam int PIN_DIR = (l == 0) ? PIN_DIRA : PIN_DIRB;
			logic [DEAD_W-1:0] deadCnt;
			logic              dirChange;
			logic              gateOk;

			assign dirChange = clean[PIN_DIR] ^ cleanPrev[PIN_DIR];
			assign gateOk = bridgeActive & ~dirChange &
				(deadCnt == '0);

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					deadCnt <= '0;
				end else if (dirChange) begin
					deadCnt <= deadCycles;
				end else if (deadCnt != '0) begin
					deadCnt <= deadCnt - DEAD_W'(1);
				end
			end

			// Both gates decode one level, so they can never overlap
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					highSideOn[l] <= 1'b0;
					lowSideOn[l]  <= 1'b0;
				end else begin
					highSideOn[l] <= gateOk & clean[PIN_DIR];
					lowSideOn[l]  <= gateOk & ~clean[PIN_DIR];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Fault flag
	logic faultPull;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			faultPull <= 1'b0;
		end else begin
			faultPull <= |(faultCond & faultMask);
		end
	end

	assign link.faultFlagNOut = 1'b0;
	assign link.faultFlagNOe  = faultPull;

endmodule

`default_nettype wire

// ==== hbridge_link_monitor.sv ====
// Checker for the serial link between the host and bridge ends.
// Assumes one system clock for both ends and host-framed transfers.
`timescale 1ns/1ps
`default_nettype none

module hbridge_link_monitor #(
	parameter int FRAME_BITS = 16
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Link pins
	input  wire logic csN,
	input  wire logic sclk,
	input  wire logic mosi,
	input  wire logic misoOut,
	input  wire logic misoOe,
	input  wire logic faultFlagNOut,
	input  wire logic faultFlagNOe
);
	// ==========================================================
	// Falling serial edges in the current frame
	logic [7:0] fallCount;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fallCount <= 8'h00;
		end else if ($fell(csN)) begin
			fallCount <= 8'h00;
		end else if ($fell(sclk) && !csN) begin
			fallCount <= fallCount + 8'h01;
		end
	end

	// ==========================================================
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_miso_released: assert property (csN [*8] |-> !misoOe)
		else $error("miso driven while deselected");
	a_miso_driven: assert property (!csN [*8] |-> misoOe)
		else $error("miso not driven while selected");
	a_miso_holds_fall: assert property (
		$fell(sclk) && !csN |=> $stable(misoOut) [*5])
		else $error("miso changed near a falling edge");
	a_mosi_holds_high: assert property (
		$rose(sclk) |=> $stable(mosi) [*7])
		else $error("mosi moved before the sampling edge");
	a_sclk_half_period: assert property (
		$changed(sclk) |=> $stable(sclk) [*7])
		else $error("serial clock phase too short");
	a_sclk_idle_low: assert property (csN |-> !sclk)
		else $error("serial clock active while deselected");
	a_frame_edge_count: assert property (
		$rose(csN) |-> fallCount == FRAME_BITS)
		else $error("frame edge count wrong");
	a_flag_pulls_low: assert property (faultFlagNOe |-> !faultFlagNOut)
		else $error("fault flag driven high");
endmodule

`default_nettype wire

// ==== tb_hbridge_spi_pin_control.sv ====
// Bench joining host and bridge ends on one link.
// Assumes one shared clk_sys; the command FIFO sits in the host end.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin \
	fails++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, \
	(got), (exp)); end end

module tb_hbridge_spi_pin_control import hbridge_pkg::*;;
	// ==========================================================
	// Signals
	localparam int FB = 32; // Two words: readback, then the echo of the first word
	localparam int DB = 2;  // Short dead time base keeps runs brief
	typedef struct packed {logic [15:0] cmd; logic [15:0] rsp;} row_t;
	logic        clk_sys, rstn, cmdValid, cmdReady, rspValid, faultSeen;
	logic        sleepEnable, outputDisable, dirA, dirB;
	logic        sleepMode, standbyMode;
	logic [31:0] cmdData, rspData, expRsp;
	logic [7:0]  faultCond;
	logic [1:0]  highSideOn, lowSideOn;
	logic [2:0]  slewSetting;
	logic [31:0] expQ [$];
	int          fails, totalChecks, cycles;
	// Command word beside the readback it should return
	row_t rows [9] = '{'{16'hC005, 16'h0005}, '{16'h2000, 16'h4005},
		'{16'hA000, 16'h20FF}, '{16'h0000, 16'h2000},
		'{16'hC000, 16'h0005}, '{16'h4000, 16'h4000},
		'{16'h2000, 16'h4000}, '{16'hA004, 16'h2000},
		'{16'h0000, 16'h2004}};

	// ==========================================================
	// Ends, link and checker
	hbridge_link_if link();
	hbridge_spi_host #(.FRAME_BITS(FB)) u_hbridge_spi_host (
		.clk_sys(clk_sys), .rstn(rstn), .link(link),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdData(cmdData),
		.rspValid(rspValid), .rspData(rspData),
		.sleepEnable(sleepEnable), .outputDisable(outputDisable),
		.dirA(dirA), .dirB(dirB), .faultSeen(faultSeen));
	hbridge_spi_device #(.DEAD_BASE(DB)) u_hbridge_spi_device (
		.clk_sys(clk_sys), .rstn(rstn), .link(link),
		.faultCond(faultCond), .highSideOn(highSideOn),
		.lowSideOn(lowSideOn), .slewSetting(slewSetting),
		.sleepMode(sleepMode), .standbyMode(standbyMode));
	hbridge_link_monitor #(.FRAME_BITS(FB)) u_hbridge_link_monitor (
		.clk_sys(clk_sys), .rstn(rstn), .csN(link.csN),
		.sclk(link.sclk), .mosi(link.mosi), .misoOut(link.misoOut),
		.misoOe(link.misoOe), .faultFlagNOut(link.faultFlagNOut),
		.faultFlagNOe(link.faultFlagNOe));

	// ==========================================================
	// Clock, watchdog and watchers
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Ten frames of about 530 cycles plus pin tests
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 12000) begin
			fails++;
			finishTest();
		end
	end

	// Mid-cycle sampling avoids racing the flops on the rising edge
	always @(negedge clk_sys) begin
		if (rstn === 1'b1) `CHK(highSideOn & lowSideOn, 2'h0)
		if (rspValid === 1'b1) begin
			expRsp = expQ.pop_front();
			`CHK(rspData, expRsp)
		end
	end

	// ==========================================================
	// Tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Leaves cmdValid high so back-to-back calls never drop it
	task automatic pushCmd(input row_t r);
		cmdValid = 1'b1;
		cmdData  = {~r.cmd, r.cmd};
		while (cmdReady !== 1'b1) step(1);
		expQ.push_back({r.rsp, ~r.cmd});
		step(1);
	endtask

	task automatic dirSwap(input logic a, input logic b, input int dead);
		int off;
		off  = 0;
		dirA = a;
		dirB = b;
		repeat (80) begin
			step(1);
			if (highSideOn === 2'h0 && lowSideOn === 2'h0) off++;
		end
		`CHK(off >= dead && off <= dead + 6, 1'b1)
		`CHK(highSideOn, {b, a})
		`CHK(lowSideOn, ~{b, a})
	endtask

	task automatic endTest(input string name);
		$display("test %s done", name);
	endtask

	task automatic finishTest();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		{rstn, cmdValid, sleepEnable, outputDisable, dirA, dirB} = 6'h00;
		cmdData   = 32'h0;
		faultCond = 8'h05;
		step(3);
		`CHK({link.misoOe, sleepMode, standbyMode}, 3'h2)
		`CHK(slewSetting, 3'h3)
		`CHK({cmdReady, rspValid, link.csN}, 3'h5)
		rstn = 1'b1;
		step(10);
		`CHK({sleepMode, highSideOn, lowSideOn}, 5'h10)
		endTest("reset");
		sleepEnable = 1'b1;
		dirA        = 1'b1;
		step(40);
		`CHK({sleepMode, standbyMode}, 2'h0)
		`CHK({highSideOn, lowSideOn}, 4'h6)
		dirSwap(1'b0, 1'b1, DB * 4);
		outputDisable = 1'b1;
		step(10);
		`CHK({sleepMode, standbyMode, highSideOn, lowSideOn}, 6'h10)
		outputDisable = 1'b0;
		step(40);
		endTest("pins");
		// First word starts a frame, the next eight fill the FIFO
		pushCmd(rows[0]);
		cmdValid = 1'b0;
		step(20);
		for (int i = 1; i < 9; i++) begin
			`CHK(cmdReady, 1'b1)
			pushCmd(rows[i]);
		end
		cmdValid = 1'b0;
		`CHK(cmdReady, 1'b0)
		while (expQ.size() != 0) step(1);
		`CHK(cmdReady, 1'b1)
		`CHK(slewSetting, 3'h0)
		`CHK({faultSeen, link.faultFlagNOe}, 2'h3)
		pushCmd(row_t'{16'hA000, 16'h0005});
		cmdValid = 1'b0;
		while (expQ.size() != 0) step(1);
		step(20);
		`CHK(faultSeen, 1'b0)
		endTest("stream");
		dirSwap(1'b1, 1'b0, DB);
		sleepEnable = 1'b0;
		step(10);
		`CHK({sleepMode, highSideOn, lowSideOn}, 5'h10)
		endTest("slew and sleep");
		rstn = 1'b0;
		step(3);
		`CHK({link.misoOe, slewSetting}, 4'h3)
		rstn = 1'b1;
		step(5);
		`CHK({cmdReady, link.csN, link.misoOe, slewSetting}, 6'h33)
		endTest("second reset");
		finishTest();
	end
endmodule

`undef CHK
`default_nettype wire
